// ===== hdl/tspc_pkg.sv
package tspc_pkg;
   // ==========================================================
   // timing: times in their own units, counts derived from clock
   // ==========================================================
   localparam int CLK_KHZ = 10000;        // system clock, 10 MHz
   localparam int HOLD_US = 15600;        // status freeze, 15.6 ms
   localparam int VALID_NS = 31250000;    // flag validity, 31.25 ms
   localparam int HOLD_CYC = HOLD_US * (CLK_KHZ / 1000);
   localparam int VALID_CYC = (VALID_NS / 1000) * (CLK_KHZ / 1000);
   localparam int CNT_W = 20;             // holds VALID_CYC

   // ==========================================================
   // channel grid, in 100 kHz steps of absolute frequency
   // ==========================================================
   localparam int FREQ_W = 11;
   localparam logic [10:0] US_LOW = 11'h36b;   // 87.5 MHz
   localparam logic [10:0] US_HIGH = 11'h438;  // 108 MHz
   localparam logic [10:0] JP_LOW = 11'h2f8;   // 76 MHz
   localparam logic [10:0] JP_HIGH = 11'h384;  // 90 MHz
   localparam logic [10:0] FREQ_RST = 11'h36b; // tuned after reset

   // level thresholds per stop level code, four nibbles, code 0 low
   localparam logic [15:0] SSL_THR = 16'ha753;

   // ==========================================================
   // carriers and states
   // ==========================================================
   typedef struct packed {
      logic if_fail;      // if count failed at a valid level, or a search stopped at the band edge without a find
      logic band_limit;   // band edge reached
      logic tune_done;    // tuning cycle finished, or a search stepped on from a channel
   } tspc_flags_t;

   localparam tspc_flags_t FLAGS_RST = 3'h0;

   typedef struct packed {
      logic [3:0] level;  // level adc reading
      logic if_ok;        // if count inside its window
   } tspc_meas_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,    // tuned, nothing running
      ST_WAIT = 2'b01,    // waiting for a fresh measurement
      ST_HOLD = 2'b10     // status frozen after completion
   } tspc_state_t;
endpackage : tspc_pkg

// ===== hdl/tspc_tuner_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module tspc_tuner_ctrl
   import tspc_pkg::*;
#(
   parameter int HOLD_CYCLES = HOLD_CYC,    // shorten in simulation
   parameter int VALID_CYCLES = VALID_CYC   // shorten in simulation
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic meas_clk_i,
   input wire logic [3:0] level_i,
   input wire logic if_ok_i,
   input wire logic meas_valid_i,
   input wire logic tune_word_wr_i,
   input wire logic tune_word_high_byte_i,
   input wire logic [10:0] tune_word_i,
   input wire logic search_mode_select_i,
   input wire logic search_direction_i,
   input wire logic [1:0] stop_level_field_i,
   input wire logic auto_injection_stop_i,
   input wire logic band_japan_i,
   input wire logic [2:0] irq_mask_i,
   input wire logic irq_mask_wr_i,
   input wire logic irq_status_rd_i,
   input wire logic port_level_bit_i,
   input wire logic port_source_select_i,
   input wire logic test_mode_select_i,
   input wire logic [1:0] power_state_bits_i,
   output logic [10:0] tuned_freq_readback_o,
   output logic [10:0] tuner_freq_o,
   output logic [2:0] irq_flags_o,
   output logic [2:0] irq_mask_o,
   output logic irq_line_n_o,
   output logic user_output_pin_o,
   output logic radio_pd_o,
   output logic audio_hiz_o,
   output logic busy_o
);

   // ==========================================================
   // decode helpers
   // ==========================================================
   // level threshold for a stop level code
   function automatic logic [3:0] ssl_thr(input logic [1:0] code);
      ssl_thr = SSL_THR[{code, 2'b00} +: 4];
   endfunction : ssl_thr

   // ==========================================================
   // link side: capture measurements on the front end clock
   // ==========================================================
   tspc_meas_t meas_hold_r;     // last reading, quasi static
   logic meas_tog_r;            // flips once per reading
   logic meas_vld_s1_r;         // pin synchroniser, stage one
   logic meas_vld_s2_r;         // pin synchroniser, stage two
   logic meas_vld_s3_r;         // previous value, edge detect

   // the strobe is a pin: two flops before any logic looks at it
   always_ff @(posedge meas_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         meas_vld_s1_r <= 1'b0;
         meas_vld_s2_r <= 1'b0;
         meas_vld_s3_r <= 1'b0;
      end else begin
         meas_vld_s1_r <= meas_valid_i;
         meas_vld_s2_r <= meas_vld_s1_r;
         meas_vld_s3_r <= meas_vld_s2_r;
      end
   end

   // data pins pass two flops too, then are held for the crossing
   logic [4:0] meas_s1_r;
   logic [4:0] meas_s2_r;
   always_ff @(posedge meas_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         meas_s1_r <= 5'h00;
         meas_s2_r <= 5'h00;
      end else begin
         meas_s1_r <= {level_i, if_ok_i};
         meas_s2_r <= meas_s1_r;
      end
   end

   // a new reading freezes its word and flips the toggle; the word
   // is stable long before the toggle arrives on the other side
   always_ff @(posedge meas_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         meas_hold_r <= '0;
         meas_tog_r <= 1'b0;
      end else if (meas_vld_s2_r && !meas_vld_s3_r) begin
         meas_hold_r <= meas_s2_r;
         meas_tog_r <= !meas_tog_r;
      end
   end

   // ==========================================================
   // crossing into the system clock
   // ==========================================================
   logic tog_s1_r;              // first stage, read by s2 only
   logic tog_s2_r;
   logic tog_s3_r;
   tspc_meas_t meas_r;          // reading on the system side
   logic meas_evt_r;            // one cycle per new reading

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tog_s1_r <= 1'b0;
         tog_s2_r <= 1'b0;
         tog_s3_r <= 1'b0;
      end else begin
         tog_s1_r <= meas_tog_r;
         tog_s2_r <= tog_s1_r;
         tog_s3_r <= tog_s2_r;
      end
   end

   // word is sampled when the toggle change is seen
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         meas_r <= '0;
         meas_evt_r <= 1'b0;
      end else begin
         meas_evt_r <= tog_s2_r ^ tog_s3_r;
         if (tog_s2_r ^ tog_s3_r) begin
            meas_r <= meas_hold_r;
         end
      end
   end

   // ==========================================================
   // channel checks
   // ==========================================================
   logic powered;               // radio circuits running
   logic lvl_ok;                // level at or above stop level
   logic found;                 // both checks pass
   logic at_edge;               // next step leaves the band
   logic [10:0] band_lo;
   logic [10:0] band_hi;

   assign powered = (power_state_bits_i != 2'b00);
   assign band_lo = band_japan_i ? JP_LOW : US_LOW;
   assign band_hi = band_japan_i ? JP_HIGH : US_HIGH;
   assign lvl_ok = (meas_r.level >= ssl_thr(stop_level_field_i));
   assign found = lvl_ok && meas_r.if_ok;
   assign at_edge = search_direction_i ? (tuner_freq_o >= band_hi)
                                       : (tuner_freq_o <= band_lo);

   // ==========================================================
   // tuning sequencer
   // ==========================================================
   tspc_state_t state_r;
   logic search_r;              // running cycle is a search
   logic finish;                // cycle ends this clock
   tspc_flags_t fin_flags;      // flags a decided reading sets, a search step included
   logic step;                  // search moves one channel
   logic start;
   logic settle_r;              // next reading may predate the last move
   logic [CNT_W-1:0] cnt_r;     // time since completion

   assign start = tune_word_wr_i && powered &&
                  (search_mode_select_i || tune_word_high_byte_i);

   // decide the outcome of one measurement
   always_comb begin
      finish = 1'b0;
      step = 1'b0;
      fin_flags = FLAGS_RST;
      if (state_r == ST_WAIT && meas_evt_r && !settle_r) begin
         if (!search_r) begin
            // a preset always ends on its first reading after the settle
            finish = 1'b1;
            fin_flags.if_fail = lvl_ok && !meas_r.if_ok;
         end else if (found) begin
            finish = 1'b1;
            fin_flags.band_limit = at_edge;
         end else if (lvl_ok && auto_injection_stop_i) begin
            finish = 1'b1;
            fin_flags.if_fail = 1'b1;
         end else if (at_edge) begin
            finish = 1'b1;
            fin_flags.band_limit = 1'b1;
            fin_flags.if_fail = 1'b1;
         end else begin
            step = 1'b1;
         end
         fin_flags.tune_done = 1'b1;
      end
   end

   // state: a new write is taken only in idle, not during a running cycle or the hold
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_r <= ST_IDLE;
         search_r <= 1'b0;
         settle_r <= 1'b0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (start) begin
                  state_r <= ST_WAIT;
                  search_r <= search_mode_select_i;
                  settle_r <= 1'b1;
               end
            end
            ST_WAIT: begin
               settle_r <= step || (settle_r && !meas_evt_r);
               if (!powered) begin
                  state_r <= ST_IDLE; // standby aborts; a finishing reading that same clock still sets flags
               end else if (finish) begin
                  state_r <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               if (cnt_r >= CNT_W'(HOLD_CYCLES - 1)) begin
                  state_r <= ST_IDLE;
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // tuned frequency: load on a high byte write, one grid step per miss
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tuner_freq_o <= FREQ_RST;
      end else if (state_r == ST_IDLE && start &&
                   tune_word_high_byte_i) begin
         tuner_freq_o <= tune_word_i;
      end else if (step) begin
         tuner_freq_o <= search_direction_i ? tuner_freq_o + 11'h001
                                            : tuner_freq_o - 11'h001;
      end
   end

   // time since completion, saturating at the validity window
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_r <= '0;
      end else if (finish) begin
         cnt_r <= '0;
      end else if (cnt_r < CNT_W'(VALID_CYCLES)) begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   // ==========================================================
   // flags, masks, readback
   // ==========================================================
   tspc_flags_t flags_r;
   logic late_fail;             // later if count miss, after window

   // only after the window may a fresh reading move the flag
   assign late_fail = (state_r == ST_IDLE) && meas_evt_r &&
                      (cnt_r >= CNT_W'(VALID_CYCLES)) &&
                      lvl_ok && !meas_r.if_ok;

   // a set in the same cycle as a read wins over the clear
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         flags_r <= FLAGS_RST;
      end else begin
         if (irq_status_rd_i && state_r != ST_HOLD) begin
            flags_r <= fin_flags;
         end else begin
            flags_r <= flags_r | fin_flags;
         end
         if (late_fail) begin
            flags_r.if_fail <= 1'b1;
         end
      end
   end

   // masks clear on a status read; a write in that cycle wins
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         irq_mask_o <= 3'h0;
      end else if (irq_mask_wr_i) begin
         irq_mask_o <= irq_mask_i;
      end else if (irq_status_rd_i && state_r != ST_HOLD) begin
         irq_mask_o <= 3'h0;
      end
   end

   // status is frozen during the hold
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tuned_freq_readback_o <= FREQ_RST;
         irq_flags_o <= 3'h0;
         irq_line_n_o <= 1'b1;
      end else begin
         if (state_r != ST_HOLD || finish) begin
            tuned_freq_readback_o <= tuner_freq_o;
         end
         irq_flags_o <= flags_r;
         // low while any enabled flag is set
         irq_line_n_o <= !(|(flags_r & irq_mask_o));
      end
   end

   // ==========================================================
   // port, power and mute
   // ==========================================================
   // the port ignores power state so peripherals keep control
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         user_output_pin_o <= 1'b0;
      end else if (test_mode_select_i) begin
         user_output_pin_o <= meas_evt_r ^ user_output_pin_o;
      end else if (port_source_select_i) begin
         user_output_pin_o <= flags_r.tune_done;
      end else begin
         user_output_pin_o <= port_level_bit_i;
      end
   end

   // reset and standby: radio down, audio high impedance
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         radio_pd_o <= 1'b1;
         audio_hiz_o <= 1'b1;
         busy_o <= 1'b0;
      end else begin
         radio_pd_o <= !powered;
         audio_hiz_o <= !powered;
         busy_o <= (state_r == ST_WAIT);
      end
   end

   // ==========================================================
   // checks
   // ==========================================================
   chk_irq_gate: assert property (@(posedge clk_i)
      disable iff (sys_rst_i) ((|(flags_r & irq_mask_o)) |=> !irq_line_n_o))
      else $error("irq line not low for enabled flag");
   chk_irq_release: assert property (@(posedge clk_i)
      disable iff (sys_rst_i)
      (!(|(flags_r & irq_mask_o)) |=> irq_line_n_o))
      else $error("irq line low with no enabled flag");
   chk_done_sets: assert property (@(posedge clk_i)
      disable iff (sys_rst_i)
      (finish |=> flags_r.tune_done ##1 irq_flags_o[0]))
      else $error("completion did not set done flag");
   chk_hold_freeze: assert property (@(posedge clk_i)
      disable iff (sys_rst_i)
      (state_r == ST_HOLD && $past(state_r) == ST_HOLD |=>
       $stable(tuned_freq_readback_o)))
      else $error("readback moved during hold");
   chk_step_dir: assert property (@(posedge clk_i)
      disable iff (sys_rst_i) (step && search_direction_i |=>
       tuner_freq_o == $past(tuner_freq_o) + 11'h001))
      else $error("upward step not one channel");
   chk_band_stop: assert property (@(posedge clk_i)
      disable iff (sys_rst_i) (finish && search_r && !lvl_ok && at_edge |=>
       flags_r.band_limit && flags_r.if_fail))
      else $error("band edge stop flags wrong");
   chk_lvl_first: assert property (@(posedge clk_i)
      disable iff (sys_rst_i) (finish && search_r && !fin_flags.if_fail |->
       lvl_ok))
      else $error("search stopped below stop level");
   chk_standby_mute: assert property (@(posedge clk_i)
      disable iff (sys_rst_i)
      (!powered ##1 !powered |-> audio_hiz_o && radio_pd_o))
      else $error("standby not muted");
   chk_port_mux: assert property (@(posedge clk_i)
      disable iff (sys_rst_i) (!test_mode_select_i && !port_source_select_i
       |=> user_output_pin_o == $past(port_level_bit_i)))
      else $error("port does not follow level bit");
endmodule : tspc_tuner_ctrl
`default_nettype wire

// ===== dv/tspc_front_end_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// front end model: level and if readings per tuned channel
// ==========================================================
module tspc_front_end_model
   import tspc_pkg::*;
(
   input wire logic meas_clk_i,
   input wire logic sys_rst_i,
   input wire logic [10:0] tuner_freq_i,
   input wire logic [10:0] stn_freq_i,
   input wire logic [3:0] stn_level_i,
   input wire logic [10:0] alt_freq_i,
   input wire logic [3:0] alt_level_i,
   input wire logic alt_if_ok_i,
   input wire logic [3:0] gap_i,
   output logic [3:0] level_o,
   output logic if_ok_o,
   output logic meas_valid_o
);
   logic [4:0] ph_r; // phase inside one reading period
   // one reading per period; gap_i stretches it for a slow front end
   // the tuned word is sampled long after it settled, so no sync
   always_ff @(posedge meas_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ph_r <= 5'h00;
         level_o <= 4'h0;
         if_ok_o <= 1'b0;
         meas_valid_o <= 1'b0;
      end else begin
         ph_r <= (ph_r >= 5'h0c + {1'b0, gap_i}) ? 5'h00 : ph_r + 5'h01;
         if (ph_r == 5'h00) begin
            // wanted station, decoy, or noise with a bad if count
            if (tuner_freq_i === stn_freq_i) begin
               level_o <= stn_level_i;
               if_ok_o <= 1'b1;
            end else if (tuner_freq_i === alt_freq_i) begin
               level_o <= alt_level_i;
               if_ok_o <= alt_if_ok_i;
            end else begin
               level_o <= 4'h0;
               if_ok_o <= 1'b0;
            end
         end else if (ph_r == 5'h04) begin
            meas_valid_o <= 1'b1; // data stable four clocks already
         end else if (ph_r == 5'h08) begin
            meas_valid_o <= 1'b0;
         end else if (ph_r == 5'h0a) begin
            // hold time over: stale data must not look valid
            level_o <= ~level_o;
            if_ok_o <= ~if_ok_o;
         end
      end
   end
endmodule : tspc_front_end_model
`default_nettype wire

// ===== dv/tspc_tuner_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none
module tspc_tuner_ctrl_tb;
   import tspc_pkg::*;
   // ==========================================================
   // signals, clocks and instances
   // ==========================================================
   localparam int HOLD = 20; // shortened status freeze
   logic clk, mclk, rst, wr, hb, srch, dir, ais, mwr, rd, plev, psel, tm;
   logic a_ok, ifok, mval, irq_n, pin, pd, hiz, busy;
   logic [10:0] word, freq_o, rb_o, s_freq, a_freq;
   logic [3:0] lvl, s_lvl, a_lvl, gap;
   logic [2:0] mask, flags_o, mask_o;
   logic [1:0] code, pwr;
   int miscompares, n_compared;
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // link clock, unrelated phase
   initial begin
      mclk = 1'b0;
      #37;
      forever #80 mclk = ~mclk;
   end
   tspc_tuner_ctrl #(.HOLD_CYCLES(HOLD), .VALID_CYCLES(40)) i_dut (
      .clk_i(clk), .sys_rst_i(rst), .meas_clk_i(mclk), .level_i(lvl),
      .if_ok_i(ifok), .meas_valid_i(mval), .tune_word_wr_i(wr),
      .tune_word_high_byte_i(hb), .tune_word_i(word),
      .search_mode_select_i(srch), .search_direction_i(dir),
      .stop_level_field_i(code), .auto_injection_stop_i(ais),
      .band_japan_i(1'b0), .irq_mask_i(mask), .irq_mask_wr_i(mwr),
      .irq_status_rd_i(rd), .port_level_bit_i(plev),
      .port_source_select_i(psel), .test_mode_select_i(tm),
      .power_state_bits_i(pwr), .tuned_freq_readback_o(rb_o),
      .tuner_freq_o(freq_o), .irq_flags_o(flags_o), .irq_mask_o(mask_o),
      .irq_line_n_o(irq_n), .user_output_pin_o(pin), .radio_pd_o(pd),
      .audio_hiz_o(hiz), .busy_o(busy));
   tspc_front_end_model i_fe (
      .meas_clk_i(mclk), .sys_rst_i(rst), .tuner_freq_i(freq_o),
      .stn_freq_i(s_freq), .stn_level_i(s_lvl), .alt_freq_i(a_freq),
      .alt_level_i(a_lvl), .alt_if_ok_i(a_ok), .gap_i(gap),
      .level_o(lvl), .if_ok_o(ifok), .meas_valid_o(mval));
   // ==========================================================
   // shared tasks
   // ==========================================================
   task automatic chk(input string what, input logic [10:0] seen,
                      input logic [10:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : tally_and_finish
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   // write the tune word, then wait for the cycle to finish
   task automatic tune(input logic [10:0] f, input logic h, input logic s);
      int n;
      word = f;
      hb = h;
      srch = s;
      wr = 1'b1;
      cyc(1);
      wr = 1'b0;
      // busy rises one edge after the write is taken
      cyc(1);
      n = 0;
      while (busy !== 1'b0 && n < 4000) begin
         cyc(1);
         n++;
      end
      if (n == 4000) chk("busy", busy, 1'b0);
      cyc(4);
   endtask : tune
   task automatic set_mask(input logic [2:0] m);
      mask = m;
      mwr = 1'b1;
      cyc(1);
      mwr = 1'b0;
      cyc(1);
      chk("mask set", mask_o, m);
   endtask : set_mask
   // wait out the freeze, then read status to clear it
   task automatic clear_hold;
      cyc(HOLD + 5);
      rd = 1'b1;
      cyc(1);
      rd = 1'b0;
      cyc(2);
      chk("flags clr", flags_o, 3'h0);
      chk("mask clr", mask_o, 3'h0);
      chk("irq off", irq_n, 1'b1);
   endtask : clear_hold
   task automatic srch_run(input logic [10:0] st, input logic h,
      input logic d, input logic [10:0] ef, input logic [2:0] efl,
      input logic [2:0] m);
      set_mask(m);
      dir = d;
      tune(st, h, 1'b1);
      chk("freq", freq_o, ef);
      chk("readback", rb_o, ef);
      chk("flags", flags_o, efl);
      chk("irq", irq_n, ~|(efl & m));
      clear_hold();
   endtask : srch_run
   // ==========================================================
   // scenarios
   // ==========================================================
   task automatic t_reset;
      chk("pd", pd, 1'b1);
      chk("hiz", hiz, 1'b1);
      chk("freq", freq_o, FREQ_RST);
      chk("flags", flags_o, 3'h0);
      chk("irq", irq_n, 1'b1);
      plev = 1'b1;
      cyc(2);
      chk("pin standby", pin, 1'b1);
      tune(11'h3e9, 1'b1, 1'b0);
      chk("standby freq", freq_o, FREQ_RST);
      pwr = 2'b01;
      cyc(2);
      chk("pd on", pd, 1'b0);
      chk("hiz on", hiz, 1'b0);
   endtask : t_reset
   task automatic t_preset;
      psel = 1'b1;
      s_freq = 11'h3e9;
      s_lvl = 4'ha;
      set_mask(3'h1);
      tune(11'h3e9, 1'b1, 1'b0);
      chk("freq", freq_o, 11'h3e9);
      chk("flags", flags_o, 3'h1);
      chk("irq", irq_n, 1'b0);
      chk("pin done", pin, 1'b1);
      rd = 1'b1;
      cyc(1);
      rd = 1'b0;
      cyc(2);
      chk("frozen", flags_o, 3'h1);
      clear_hold();
      chk("pin clr", pin, 1'b0);
      psel = 1'b0;
   endtask : t_preset
   task automatic t_up;
      code = 2'h1;
      s_freq = 11'h3e4;
      s_lvl = 4'h6;
      a_freq = 11'h3e2;
      a_lvl = 4'ha;
      a_ok = 1'b0;
      srch_run(11'h3e0, 1'b1, 1'b1, 11'h3e4, 3'h1, 3'h1);
   endtask : t_up
   task automatic t_down;
      code = 2'h2;
      s_lvl = 4'h8;
      a_freq = 11'h3e5;
      a_lvl = 4'h6;
      a_ok = 1'b1;
      srch_run(11'h3e6, 1'b1, 1'b0, 11'h3e4, 3'h1, 3'h1);
   endtask : t_down
   task automatic t_here;
      s_freq = 11'h3e7;
      a_freq = 11'h000;
      srch_run(11'h400, 1'b0, 1'b1, 11'h3e7, 3'h1, 3'h1);
   endtask : t_here
   task automatic t_edges;
      code = 2'h3;
      s_freq = 11'h36d;
      gap = 4'h6;
      srch_run(11'h36e, 1'b1, 1'b0, 11'h36b, 3'h7, 3'h0);
      gap = 4'h0;
      code = 2'h2;
      s_freq = 11'h36b;
      s_lvl = 4'ha;
      srch_run(11'h36d, 1'b1, 1'b0, 11'h36b, 3'h3, 3'h2);
   endtask : t_edges
   task automatic t_port;
      logic p;
      int n;
      plev = 1'b1;
      cyc(2);
      chk("pin lvl1", pin, 1'b1);
      plev = 1'b0;
      cyc(2);
      chk("pin lvl0", pin, 1'b0);
      tm = 1'b1;
      p = pin;
      n = 0;
      while (pin === p && n < 100) begin
         cyc(1);
         n++;
      end
      chk("test toggle", pin !== p, 1'b1);
      tm = 1'b0;
   endtask : t_port
   task automatic t_if_stop;
      ais = 1'b1;
      code = 2'h1;
      s_freq = 11'h3e4;
      a_freq = 11'h3e2;
      a_lvl = 4'ha;
      a_ok = 1'b0;
      srch_run(11'h3e0, 1'b1, 1'b1, 11'h3e2, 3'h5, 3'h1);
      // past the validity window a fresh if miss may set the flag again
      cyc(60);
      chk("late if", flags_o, 3'h4);
   endtask : t_if_stop
   // ==========================================================
   // main sequence and watchdog
   // ==========================================================
   initial begin
      {wr, hb, srch, dir, ais, mwr, rd, plev, psel, tm, a_ok} = 11'h000;
      word = 11'h000;
      s_freq = 11'h000;
      a_freq = 11'h000;
      s_lvl = 4'h0;
      a_lvl = 4'h0;
      gap = 4'h0;
      mask = 3'h0;
      code = 2'h0;
      pwr = 2'b00;
      miscompares = 0;
      n_compared = 0;
      rst = 1'b1;
      cyc(20);
      rst = 1'b0;
      cyc(1);
      t_reset();
      t_preset();
      t_up();
      t_down();
      t_here();
      t_edges();
      t_port();
      t_if_stop();
      tally_and_finish();
   end
   // whole run needs a few thousand cycles; 50000 is ample
   initial begin
      #5000000;
      miscompares++;
      tally_and_finish();
   end
endmodule : tspc_tuner_ctrl_tb
`default_nettype wire
